/* core/capcom_pkg.sv */
// Constants for the sixteen channel capture/compare unit.
// Assumes a single 40 MHz clock and a plain strobe register port.
package capcom_pkg;

  // ---------------------------------------------------------------
  // Sizes
  // ---------------------------------------------------------------
  localparam int NUM_CH = 16;
  localparam int CNT_W = 16;
  localparam int ADDR_W = 6;
  localparam int STAGGER_CYCLES = 8;

  // ---------------------------------------------------------------
  // Register map (word index on the strobe port)
  // ---------------------------------------------------------------
  localparam logic [5:0] ADDR_CTRL = 6'h00;
  localparam logic [5:0] ADDR_CNT_A = 6'h01;
  localparam logic [5:0] ADDR_REL_A = 6'h02;
  localparam logic [5:0] ADDR_CNT_B = 6'h03;
  localparam logic [5:0] ADDR_REL_B = 6'h04;
  localparam logic [5:0] ADDR_FLAGS = 6'h05;
  localparam logic [5:0] ADDR_PINS = 6'h06;
  localparam logic [5:0] ADDR_VAL_BASE = 6'h10;
  localparam logic [5:0] ADDR_MODE_BASE = 6'h20;

  // ---------------------------------------------------------------
  // Control register fields
  // ---------------------------------------------------------------
  localparam int CTRL_RUN_A = 0;
  localparam int CTRL_SRC_A_LO = 1;
  localparam int CTRL_RUN_B = 4;
  localparam int CTRL_SRC_B_LO = 5;
  localparam int CTRL_STAGGER = 8;
  localparam logic [15:0] CTRL_RESET = 16'h0000;

  // Channel mode register fields
  localparam int MODE_FN_LO = 0;
  localparam int MODE_TIMER_B = 3;
  localparam int MODE_SINGLE = 4;
  localparam int MODE_DOUBLE = 5;

  // Count clock source select (3 bits)
  localparam logic [2:0] SRC_DIV1 = 3'h0;
  localparam logic [2:0] SRC_DIV8 = 3'h1;
  localparam logic [2:0] SRC_DIV64 = 3'h2;
  localparam logic [2:0] SRC_DIV512 = 3'h3;
  localparam logic [2:0] SRC_GPT = 3'h4;
  localparam logic [2:0] SRC_EXT = 3'h5;

  // Channel functions (3 bits)
  localparam logic [2:0] FN_OFF = 3'h0;
  localparam logic [2:0] FN_CAP_RISE = 3'h1;
  localparam logic [2:0] FN_CAP_FALL = 3'h2;
  localparam logic [2:0] FN_CAP_BOTH = 3'h3;
  localparam logic [2:0] FN_CMP0 = 3'h4;
  localparam logic [2:0] FN_CMP1 = 3'h5;
  localparam logic [2:0] FN_CMP2 = 3'h6;
  localparam logic [2:0] FN_CMP3 = 3'h7;

endpackage

/* core/capcom_unit.sv */
// Sixteen channel capture/compare unit with two reloadable time bases.
// Assumes pins and count inputs are asynchronous to mclk; registers are
// reached over a strobe port with read data one cycle after the strobe.
//
// Notes on behaviour
// - Sixteen channels; stagger gives eight-cycle resolution
// - Two 16-bit counters each with reload register
// - Count clock: prescaled system clock or timer overflow
// - First counter also counts an external input
// - Each channel picks counter and capture/compare
// - Each channel owns one pin, in or out
// - Capture latches counter and raises channel interrupt
// - Capture edge: rising, falling, or both
// - Compare every cycle, or every eighth when staggered; on match act by mode
// - Mode 0: interrupt only, repeated matches allowed
// - Mode 1: pin toggles on every match
// - Mode 2: interrupt only, once per period
// - Mode 3: set on match, clear on overflow
// - Double register: two channels toggle one pin
// - Single event option stops a compare channel after one event
//
// Design decisions made here: the register offsets and strobed register access.
`timescale 1ns/1ps

module capcom_unit
  import capcom_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // Register port
  input wire logic [ADDR_W-1:0] regAddr,
  input wire logic [15:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [15:0] regRdata,
  // Count sources
  input wire logic gpTimerOvf,
  input wire logic extCountIn,
  // Channel pins
  input wire logic [NUM_CH-1:0] chPinIn,
  output logic [NUM_CH-1:0] chPinOut,
  output logic [NUM_CH-1:0] chPinOe,
  // Per-channel interrupt requests
  output logic [NUM_CH-1:0] chIrq
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  logic [15:0] ctrl_q;
  logic [CNT_W-1:0] cntA_q, cntB_q, relA_q, relB_q;
  logic [CNT_W-1:0] chVal_q [NUM_CH];
  logic [5:0] chMode_q [NUM_CH];
  logic [NUM_CH-1:0] doneP_q, doneS_q, pinState_q, irqFlag_q;
  logic [NUM_CH-1:0] pinMeta_q, pinSync_q, pinPrev_q;
  logic [1:0] gpSync_q, extSync_q;
  logic gpPrev_q, extPrev_q;
  logic [8:0] prescale_q;
  logic [2:0] stagger_q;

  // Tick from the chosen source; external inputs count on rising edges
  function automatic logic srcTick(input logic [2:0] src, input logic [8:0] pre,
                                   input logic gpEdge, input logic extEdge);
    unique case (src)
      SRC_DIV1: srcTick = 1'b1;
      SRC_DIV8: srcTick = (pre[2:0] == 3'h7);
      SRC_DIV64: srcTick = (pre[5:0] == 6'h3f);
      SRC_DIV512: srcTick = (pre == 9'h1ff);
      SRC_GPT: srcTick = gpEdge;
      SRC_EXT: srcTick = extEdge;
      default: srcTick = 1'b0;
    endcase
  endfunction

  // ---------------------------------------------------------------
  // Input synchronisers
  // ---------------------------------------------------------------
  // Two stages before any logic; the first stage feeds only the second
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      pinMeta_q <= '0;
      pinSync_q <= '0;
      pinPrev_q <= '0;
      gpSync_q <= 2'h0;
      extSync_q <= 2'h0;
      gpPrev_q <= 1'b0;
      extPrev_q <= 1'b0;
    end else begin
      pinMeta_q <= chPinIn;
      pinSync_q <= pinMeta_q;
      pinPrev_q <= pinSync_q;
      gpSync_q <= {gpSync_q[0], gpTimerOvf};
      extSync_q <= {extSync_q[0], extCountIn};
      gpPrev_q <= gpSync_q[1];
      extPrev_q <= extSync_q[1];
    end
  end

  logic gpEdge, extEdge, tickA, tickB, stagTick, ovfA, ovfB;
  logic [NUM_CH-1:0] pinRise, pinFall;
  assign gpEdge = gpSync_q[1] & ~gpPrev_q;
  assign extEdge = extSync_q[1] & ~extPrev_q;
  assign pinRise = pinSync_q & ~pinPrev_q;
  assign pinFall = ~pinSync_q & pinPrev_q;

  // ---------------------------------------------------------------
  // Prescaler and time bases
  // ---------------------------------------------------------------
  // Free-running prescaler shared by both counters
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      prescale_q <= 9'h000;
      stagger_q <= 3'h0;
    end else begin
      prescale_q <= prescale_q + 9'h001;
      stagger_q <= stagger_q + 3'h1;
    end
  end

  // Staggered mode services all channels once every eight cycles
  assign stagTick = ~ctrl_q[CTRL_STAGGER] | (stagger_q == 3'(STAGGER_CYCLES - 1));
  assign tickA = ctrl_q[CTRL_RUN_A] &
                 srcTick(ctrl_q[CTRL_SRC_A_LO +: 3], prescale_q, gpEdge, extEdge);
  // The external count input belongs to the first counter only
  assign tickB = ctrl_q[CTRL_RUN_B] & (ctrl_q[CTRL_SRC_B_LO +: 3] != SRC_EXT) &
                 srcTick(ctrl_q[CTRL_SRC_B_LO +: 3], prescale_q, gpEdge, extEdge);
  assign ovfA = tickA & (cntA_q == 16'hffff);
  assign ovfB = tickB & (cntB_q == 16'hffff);

  // Counters count up and reload on overflow; software writes win
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      cntA_q <= 16'h0000;
      cntB_q <= 16'h0000;
    end else begin
      if (regWr && regAddr == ADDR_CNT_A) cntA_q <= regWdata;
      else if (ovfA) cntA_q <= relA_q;
      else if (tickA) cntA_q <= cntA_q + 16'h0001;
      if (regWr && regAddr == ADDR_CNT_B) cntB_q <= regWdata;
      else if (ovfB) cntB_q <= relB_q;
      else if (tickB) cntB_q <= cntB_q + 16'h0001;
    end
  end

  // Control and reload registers
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_q <= CTRL_RESET;
      relA_q <= 16'h0000;
      relB_q <= 16'h0000;
    end else if (regWr) begin
      if (regAddr == ADDR_CTRL) ctrl_q <= regWdata;
      if (regAddr == ADDR_REL_A) relA_q <= regWdata;
      if (regAddr == ADDR_REL_B) relB_q <= regWdata;
    end
  end

  // ---------------------------------------------------------------
  // Channel array
  // ---------------------------------------------------------------
  logic [NUM_CH-1:0] capHit, cmpHit, chOvf, pinSet, pinClr, pinTgl, irqSet;

  // Per-channel decode of capture trigger, match and pin action
  always_comb begin
    for (int i = 0; i < NUM_CH; i++) begin
      logic [2:0] fn;
      logic useB;
      logic [CNT_W-1:0] cnt;
      logic done;
      fn = chMode_q[i][MODE_FN_LO +: 3];
      useB = chMode_q[i][MODE_TIMER_B];
      cnt = useB ? cntB_q : cntA_q;
      chOvf[i] = useB ? ovfB : ovfA;
      done = doneS_q[i] | (((fn == FN_CMP2) | (fn == FN_CMP3)) & doneP_q[i]);
      unique case (fn)
        FN_CAP_RISE: capHit[i] = pinRise[i];
        FN_CAP_FALL: capHit[i] = pinFall[i];
        FN_CAP_BOTH: capHit[i] = pinRise[i] | pinFall[i];
        default: capHit[i] = 1'b0;
      endcase
      // Match is checked against the live counter every serviced cycle
      cmpHit[i] = fn[2] & stagTick & (chVal_q[i] == cnt) & ~done;
      pinSet[i] = cmpHit[i] & (fn == FN_CMP3);
      pinClr[i] = chOvf[i] & (fn == FN_CMP3) & ~doneS_q[i];
      pinTgl[i] = cmpHit[i] & (fn == FN_CMP1);
      irqSet[i] = capHit[i] | cmpHit[i];
    end
    // Even channel in double mode: its odd partner's match also toggles the even pin
    for (int i = 0; i < NUM_CH; i += 2) begin
      if (chMode_q[i][MODE_DOUBLE]) begin
        pinTgl[i] = (cmpHit[i] | cmpHit[i+1]) &
                    ((chMode_q[i][2:0] == FN_CMP1) | (chMode_q[i+1][2:0] == FN_CMP1));
      end
    end
  end

  // Channel values: capture has priority over a software write
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < NUM_CH; i++) begin
        chVal_q[i] <= 16'h0000;
        chMode_q[i] <= 6'h00;
      end
    end else begin
      for (int i = 0; i < NUM_CH; i++) begin
        if (capHit[i]) chVal_q[i] <= chMode_q[i][MODE_TIMER_B] ? cntB_q : cntA_q;
        else if (regWr && regAddr == ADDR_VAL_BASE + 6'(i)) chVal_q[i] <= regWdata;
        if (regWr && regAddr == ADDR_MODE_BASE + 6'(i)) chMode_q[i] <= regWdata[5:0];
      end
    end
  end

  // Once-per-period and single-event bookkeeping; a mode write rearms
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      doneP_q <= '0;
      doneS_q <= '0;
    end else begin
      for (int i = 0; i < NUM_CH; i++) begin
        if (regWr && regAddr == ADDR_MODE_BASE + 6'(i)) begin
          doneP_q[i] <= 1'b0;
          doneS_q[i] <= 1'b0;
        end else begin
          if (cmpHit[i]) doneP_q[i] <= 1'b1;
          else if (chOvf[i]) doneP_q[i] <= 1'b0;
          // Mode 3 single event ends after the clearing edge: one pulse
          if (chMode_q[i][MODE_SINGLE] && (chMode_q[i][2:0] == FN_CMP3 ?
              (chOvf[i] && pinState_q[i]) : cmpHit[i])) doneS_q[i] <= 1'b1;
        end
      end
    end
  end

  // Pin latches and output enables
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      pinState_q <= '0;
      chPinOe <= '0;
    end else begin
      for (int i = 0; i < NUM_CH; i++) begin
        // Pins of channels that drive are outputs, the rest are inputs
        chPinOe[i] <= (chMode_q[i][2:0] == FN_CMP1) | (chMode_q[i][2:0] == FN_CMP3) |
                      ((i % 2 == 0) && chMode_q[i][MODE_DOUBLE]);
        if (pinSet[i]) pinState_q[i] <= 1'b1;
        else if (pinClr[i]) pinState_q[i] <= 1'b0;
        else if (pinTgl[i]) pinState_q[i] <= ~pinState_q[i];
      end
    end
  end
  assign chPinOut = pinState_q;

  // Interrupt flags: an event in the clearing cycle wins over the clear
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      irqFlag_q <= '0;
      chIrq <= '0;
    end else begin
      irqFlag_q <= (regWr && regAddr == ADDR_FLAGS) ? ((irqFlag_q & ~regWdata) | irqSet)
                                                     : (irqFlag_q | irqSet);
      chIrq <= irqSet;
    end
  end

  // ---------------------------------------------------------------
  // Read path
  // ---------------------------------------------------------------
  // Read data valid in the cycle after the strobe; unmapped reads zero
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      regRdata <= 16'h0000;
    end else if (regRd) begin
      if (regAddr >= ADDR_MODE_BASE && regAddr < ADDR_MODE_BASE + 6'(NUM_CH))
        regRdata <= {10'h000, chMode_q[regAddr[3:0]]};
      else if (regAddr >= ADDR_VAL_BASE && regAddr < ADDR_VAL_BASE + 6'(NUM_CH))
        regRdata <= chVal_q[regAddr[3:0]];
      else begin
        unique case (regAddr)
          ADDR_CTRL: regRdata <= ctrl_q;
          ADDR_CNT_A: regRdata <= cntA_q;
          ADDR_REL_A: regRdata <= relA_q;
          ADDR_CNT_B: regRdata <= cntB_q;
          ADDR_REL_B: regRdata <= relB_q;
          ADDR_FLAGS: regRdata <= irqFlag_q;
          ADDR_PINS: regRdata <= pinState_q;
          default: regRdata <= 16'h0000;
        endcase
      end
    end else begin
      regRdata <= 16'h0000;
    end
  end

endmodule

/* dv/capcom_unit_asserts.sv */
// Port-level assertions for the capture/compare unit.
// Assumes it is bound to capcom_unit and sees its ports as they are.
`timescale 1ns/1ps

module capcom_unit_asserts
  import capcom_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // Register port
  input wire logic [ADDR_W-1:0] regAddr,
  input wire logic [15:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  input wire logic [15:0] regRdata,
  // Pins and requests
  input wire logic [NUM_CH-1:0] chPinOut,
  input wire logic [NUM_CH-1:0] chPinOe,
  input wire logic [NUM_CH-1:0] chIrq
);
  // ----
  // Register port
  // ----
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);

  property p_rdIdle;
    !regRd |=> regRdata == 16'h0000;
  endproperty
  a_rdIdle: assert property (p_rdIdle) else $error("read data not idle");
  property p_unmapped;
    regRd && regAddr == 6'h07 |=> regRdata == 16'h0000;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not 0");
  // Reload words read back exactly what was written the cycle before
  property p_relA;
    regWr && regAddr == ADDR_REL_A ##1 regRd && regAddr == ADDR_REL_A
      |=> regRdata == $past(regWdata, 2);
  endproperty
  a_relA: assert property (p_relA) else $error("reload A readback");
  property p_relB;
    regWr && regAddr == ADDR_REL_B ##1 regRd && regAddr == ADDR_REL_B
      |=> regRdata == $past(regWdata, 2);
  endproperty
  a_relB: assert property (p_relB) else $error("reload B readback");
  property p_ctrl;
    regWr && regAddr == ADDR_CTRL ##1 regRd && regAddr == ADDR_CTRL
      |=> regRdata[8:0] == $past(regWdata[8:0], 2);
  endproperty
  a_ctrl: assert property (p_ctrl) else $error("control readback");
  // ----
  // Pins
  // ----
  property p_resetQuiet;
    $rose(rst_b) |-> chPinOe == 16'h0000 && chIrq == 16'h0000;
  endproperty
  a_resetQuiet: assert property (p_resetQuiet) else $error("outputs busy at reset");
  // Drive direction only moves as a consequence of a mode write
  property p_oeCause;
    $changed(chPinOe) |-> $past(regWr, 2) && $past(regAddr[5:4], 2) == 2'b10;
  endproperty
  a_oeCause: assert property (p_oeCause) else $error("pin direction moved alone");
  property p_pinNeedsOe;
    ((chPinOut ^ $past(chPinOut)) & ~chPinOe & ~$past(chPinOe)) == 16'h0000;
  endproperty
  a_pinNeedsOe: assert property (p_pinNeedsOe) else $error("undriven pin moved");
  property p_cmpDrives;
    regWr && regAddr[5:4] == 2'b10 && regWdata[5:0] == 6'h05
      |=> ##1 chPinOe[$past(regAddr[3:0], 2)];
  endproperty
  a_cmpDrives: assert property (p_cmpDrives) else $error("toggle pin not driven");
  property p_capFloats;
    regWr && regAddr[5:4] == 2'b10 && !regWdata[2] && regWdata[1:0] != 2'b00
      |=> ##1 !chPinOe[$past(regAddr[3:0], 2)];
  endproperty
  a_capFloats: assert property (p_capFloats) else $error("capture pin driven");
endmodule

/* dv/pin_env.sv */
// Outside world of the unit: pad levels, timer overflow, count input.
// Assumes tasks are called just after a rising edge of mclk.
`timescale 1ns/1ps

module pin_env
  import capcom_pkg::*;
(
  // Clock
  input wire logic mclk,
  // Pin side of the unit
  input wire logic [NUM_CH-1:0] chPinOut,
  input wire logic [NUM_CH-1:0] chPinOe,
  output logic [NUM_CH-1:0] chPinIn,
  // Count sources
  output logic gpTimerOvf,
  output logic extCountIn
);
  logic [NUM_CH-1:0] padLevel = '0;
  initial gpTimerOvf = 1'b0;
  initial extCountIn = 1'b0;

  // Wire level: the unit wins where it drives, the outside level elsewhere
  assign chPinIn = (chPinOe & chPinOut) | (~chPinOe & padLevel);

  // Held long enough to pass the two-flop synchronisers
  task automatic setPads(input logic [NUM_CH-1:0] lv);
    padLevel <= lv;
    repeat (6) @(posedge mclk);
  endtask

  // Count pulses; ext picks the external input or timer overflow, hold sets cycles high and low
  task automatic pulse(input bit ext, input int n, input int hold);
    repeat (n) begin
      {extCountIn, gpTimerOvf} <= ext ? 2'b10 : 2'b01;
      repeat (hold) @(posedge mclk);
      {extCountIn, gpTimerOvf} <= 2'b00;
      repeat (hold) @(posedge mclk);
    end
  endtask
endmodule

/* dv/capcom_unit_test.sv */
// Self-checking bench for the capture/compare unit.
// Assumes the register map of capcom_pkg and pin_env as far side.
`timescale 1ns/1ps
`define CHK(got, exp) begin compares++; if ((got) !== (exp)) begin miscompares++; \
  $display("BAD %0t mismatch got %h exp %h", $time, (got), (exp)); end end

module capcom_unit_test
  import capcom_pkg::*;
;
  logic mclk, rst_b, regWr, regRd, gpTimerOvf, extCountIn;
  logic [ADDR_W-1:0] regAddr;
  logic [15:0] regWdata, regRdata;
  logic [NUM_CH-1:0] chPinIn, chPinOut, chPinOe, chIrq;
  logic [NUM_CH-1:0] lastOut = '0;
  int compares = 0;
  int miscompares = 0;
  int cycles = 0;
  int irqs [NUM_CH];
  int tog [NUM_CH];
  int rises [NUM_CH];
  logic [15:0] cfgVal [8] = '{16'hfff8, 16'hfff8, 16'hfff8, 16'hfff8,
                              16'hfff4, 16'hfffb, 16'hfff8, 16'hfffb};
  logic [5:0] cfgMode [8] = '{6'h04, 6'h05, 6'h06, 6'h07, 6'h25, 6'h05, 6'h15, 6'h0d};

  capcom_unit capcom_unit_i (.mclk(mclk), .rst_b(rst_b), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
    .gpTimerOvf(gpTimerOvf), .extCountIn(extCountIn), .chPinIn(chPinIn),
    .chPinOut(chPinOut), .chPinOe(chPinOe), .chIrq(chIrq));
  pin_env pin_env_i (.mclk(mclk), .chPinOut(chPinOut), .chPinOe(chPinOe),
    .chPinIn(chPinIn), .gpTimerOvf(gpTimerOvf), .extCountIn(extCountIn));

  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  // Tallies taken on the falling edge, so they never race the launch edge
  always @(negedge mclk) begin
    for (int i = 0; i < NUM_CH; i++) begin
      irqs[i] += int'(chIrq[i] === 1'b1);
      tog[i] += int'(chPinOut[i] !== lastOut[i]);
      rises[i] += int'(chPinOut[i] === 1'b1 && lastOut[i] === 1'b0);
    end
    lastOut = chPinOut;
  end

  // Hang guard; the whole run needs well under a thousand cycles
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 2000) begin
      miscompares++;
      summarize();
    end
  end

  // ----
  // Bus tasks: wr leaves its strobe up so a write may run straight into a read; rd drops both
  // ----
  task automatic wr(input logic [5:0] a, input logic [15:0] d);
    {regWr, regRd} <= 2'b10;
    regAddr <= a;
    regWdata <= d;
    @(posedge mclk);
  endtask
  task automatic rd(input logic [5:0] a, input logic [15:0] exp);
    {regWr, regRd} <= 2'b01;
    regAddr <= a;
    @(posedge mclk);
    {regWr, regRd} <= 2'b00;
    #1;
    `CHK(regRdata, exp)
    @(posedge mclk);
  endtask
  task automatic idle();
    {regWr, regRd} <= 2'b00;
    @(posedge mclk);
  endtask
  task automatic clearTallies();
    foreach (irqs[i]) {irqs[i], tog[i], rises[i]} = '0;
  endtask
  task automatic summarize();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  initial begin
    {rst_b, regWr, regRd} = 3'b000;
    regAddr = '0;
    regWdata = '0;
    clearTallies();
    repeat (2) @(posedge mclk);
    rst_b <= 1'b1;
    @(posedge mclk);
    rd(ADDR_CTRL, 16'h0000);
    rd(6'h07, 16'h0000);
    // Short periods: A wraps every 16 counts, B every 8
    wr(ADDR_REL_A, 16'hfff0);
    rd(ADDR_REL_A, 16'hfff0);
    wr(ADDR_CNT_A, 16'hfff0);
    wr(ADDR_REL_B, 16'hfff8);
    rd(ADDR_REL_B, 16'hfff8);
    wr(ADDR_CNT_B, 16'hfff8);
    for (int i = 7; i >= 0; i--) begin
      wr(ADDR_VAL_BASE + 6'(i), cfgVal[i]);
      wr(ADDR_MODE_BASE + 6'(i), {10'h000, cfgMode[i]});
    end
    clearTallies();
    wr(ADDR_CTRL, 16'h0011);
    rd(ADDR_CTRL, 16'h0011);
    repeat (63) @(posedge mclk);
    `CHK(irqs[0], 4)
    `CHK(tog[0], 0)
    `CHK(tog[1], 4)
    `CHK(irqs[2], 4)
    `CHK(rises[3], 4)
    `CHK(tog[4], 8)
    `CHK(tog[6], 1)
    `CHK(tog[7], 8)
    // Capture on stopped counters, so latched values are exact
    wr(ADDR_CTRL, 16'h0000);
    wr(ADDR_CNT_A, 16'h1234);
    wr(ADDR_CNT_B, 16'h0abc);
    wr(ADDR_MODE_BASE + 6'h08, 16'(FN_CAP_RISE));
    wr(ADDR_MODE_BASE + 6'h09, 16'h0008 | 16'(FN_CAP_FALL));
    wr(ADDR_MODE_BASE + 6'h0a, 16'(FN_CAP_BOTH));
    idle();
    clearTallies();
    pin_env_i.setPads(16'h0700);
    pin_env_i.setPads(16'h0000);
    `CHK(irqs[8], 1)
    `CHK(irqs[9], 1)
    `CHK(irqs[10], 2)
    rd(ADDR_VAL_BASE + 6'h08, 16'h1234);
    rd(ADDR_VAL_BASE + 6'h09, 16'h0abc);
    rd(ADDR_VAL_BASE + 6'h0a, 16'h1234);
    // Counter A from the external input, then from timer overflow
    wr(ADDR_CTRL, 16'h000b);
    idle();
    pin_env_i.pulse(1'b1, 5, 3);
    wr(ADDR_CTRL, 16'h0000);
    rd(ADDR_CNT_A, 16'h1239);
    wr(ADDR_CTRL, 16'h0009);
    idle();
    pin_env_i.pulse(1'b0, 3, 8);
    wr(ADDR_CTRL, 16'h0000);
    rd(ADDR_CNT_A, 16'h123c);
    // Divide-by-8 source holds each count for eight cycles
    wr(ADDR_VAL_BASE, 16'h123d);
    wr(ADDR_VAL_BASE + 6'h02, 16'h123d);
    clearTallies();
    wr(ADDR_CTRL, 16'h0003);
    idle();
    repeat (23) @(posedge mclk);
    `CHK(irqs[0], 8)
    `CHK(irqs[2], 1)
    // Staggered: prescaler and stagger phase coincide, so one look per count
    wr(ADDR_CTRL, 16'h0000);
    wr(ADDR_CNT_A, 16'h123c);
    clearTallies();
    wr(ADDR_CTRL, 16'h0103);
    idle();
    repeat (23) @(posedge mclk);
    `CHK(irqs[0], 1)
    wr(ADDR_CTRL, 16'h0000);
    rd(ADDR_FLAGS, 16'h07ff);
    wr(ADDR_FLAGS, 16'hffff);
    rd(ADDR_FLAGS, 16'h0000);
    rd(ADDR_PINS, 16'h0040);
    summarize();
  end
endmodule

bind capcom_unit capcom_unit_asserts capcom_unit_asserts_i (.mclk(mclk), .rst_b(rst_b),
  .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
  .regRdata(regRdata), .chPinOut(chPinOut), .chPinOe(chPinOe), .chIrq(chIrq));
